// ==== fbdc_pkg.sv ====
// Constants and types of the DRAM controller
package fbdc_pkg;

    // Clock period and refresh interval
    localparam int MEMORY_CLOCK_PERIOD_NS = 10;
    localparam int REFRESH_INTERVAL_MEMORY_CLOCK_PERIOD = 776;
    localparam int REFRESH_CYCLES         = REFRESH_INTERVAL_MEMORY_CLOCK_PERIOD;
    localparam int REFRESH_CNT_W          = 10;

    // Strobe timing in half clock periods
    localparam int RAS_TO_CAS_HALF_MEMORY_CLOCK_PERIOD  = 4;
    localparam int RAS_PRECHARGE_HALF_MEMORY_CLOCK_PERIOD = 5;
    localparam int CBR_RAS_HOLD_HALF_MEMORY_CLOCK_PERIOD  = 8;

    // Least times round up to whole cycles
    localparam logic [2:0] RAS_TO_CAS_CYCLES =
        3'((RAS_TO_CAS_HALF_MEMORY_CLOCK_PERIOD + 1) / 2);
    localparam logic [2:0] RAS_PRECHARGE_CYCLES =
        3'((RAS_PRECHARGE_HALF_MEMORY_CLOCK_PERIOD + 1) / 2);
    localparam logic [2:0] CBR_RAS_HOLD_CYCLES =
        3'((CBR_RAS_HOLD_HALF_MEMORY_CLOCK_PERIOD + 1) / 2);

    // Memory geometry
    localparam int DATA_W      = 32;
    localparam int MEM_ADDR_W  = 9;
    localparam int BYTE_ADDR_W = 22;
    localparam int BANKS       = 4;
    localparam int LANES       = 4;

    // Bank-count configuration codes
    localparam logic [1:0] BANKS_ONE  = 2'h0;
    localparam logic [1:0] BANKS_TWO  = 2'h1;
    localparam logic [1:0] BANKS_FOUR = 2'h2;

    // Access size codes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // Read return buffer depth
    localparam int RETURN_DEPTH = 4;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_PRECH   = 3'b001,
        ST_ROW     = 3'b010,
        ST_COL     = 3'b011,
        ST_STROBE  = 3'b100,
        ST_HOLD    = 3'b101,
        ST_CASUP   = 3'b110,
        ST_REFRESH = 3'b111
    } fbdc_state_t;

endpackage

// ==== fbdc_fifo.sv ====
// Shift-register FIFO with registered head
`timescale 1ns/1ps
module fbdc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // Clock and control
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             clkEn,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    logic [WIDTH-1:0] data_reg  [DEPTH];
    logic [DEPTH-1:0] valid_reg;
    logic [WIDTH-1:0] shiftData [DEPTH];
    logic [DEPTH-1:0] shiftValid;
    logic             pop;
    logic             push;

    assign pop      = valid_reg[0] && outReady;
    assign push     = inValid && inReady;
    assign inReady  = !valid_reg[DEPTH-1];
    assign outValid = valid_reg[0];
    assign outData  = data_reg[0];

    // Entries after a possible pop
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            if (pop && i < DEPTH - 1) begin
                shiftValid[i] = valid_reg[i+1];
                shiftData[i]  = data_reg[i+1];
            end else if (pop) begin
                shiftValid[i] = 1'b0;
                shiftData[i]  = data_reg[i];
            end else begin
                shiftValid[i] = valid_reg[i];
                shiftData[i]  = data_reg[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            valid_reg <= '0;
        end else if (clkEn) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (push && !shiftValid[i] &&
                    (i == 0 || shiftValid[(i == 0) ? 0 : i-1])) begin
                    valid_reg[i] <= 1'b1;
                    data_reg[i]  <= inData;
                end else begin
                    valid_reg[i] <= shiftValid[i];
                    data_reg[i]  <= shiftData[i];
                end
            end
        end
    end
endmodule

// ==== fbdc_dram_ctrl.sv ====
// Frame-buffer DRAM controller, one to four banks
//
// Overview of operation
// - Targets 4Mbit 256Kx16 DRAMs with one column strobe per byte.
// - Random reads, random EDO reads and random writes are generated.
// - Fast page reads, and hyper page EDO reads where configuration allows.
// - Page-mode writes are late writes: write strobe after column strobe.
// - Write-per-bit mask applies to its own cycle only, never retained.
// - Refresh timer requests a refresh every 776 memory clocks.
// - Every refresh is a CAS-before-RAS cycle.
// - Memory addressed uniformly as 8, 16 or 32 bit units.
// - Memory systems of one, two or four banks are supported.
// - Each bank is two 256Kx16 devices: 256K words of 32 bits.
// - One shared 32-bit data bus, two 9-bit multiplexed address buses.
// - Strobes for up to four banks, with two-way bank interleave.
// - Hyper page only for 1MByte, or 2/4MByte with the wide DAC.
// - Standard DRAM, narrow DAC, 2MByte: two banks interleaved.
// - Standard DRAM, wide DAC, 4MByte: banks interleaved.
// - Strobe timing counted in whole memory clock periods.
// - Even and odd bank pairs use separate address buses and each keep a row open.
`timescale 1ns/1ps
module fbdc_dram_ctrl (
    // Clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        clkEn,
    // Memory configuration
    input  wire logic [1:0]  cfgBankCount,
    input  wire logic        cfgWideDac,
    input  wire logic        cfgEdoDram,
    // Access requests
    input  wire logic        reqValid,
    output logic             reqReady,
    input  wire logic        reqWrite,
    input  wire logic [21:0] reqAddr,
    input  wire logic [1:0]  reqSize,
    input  wire logic [31:0] reqWriteData,
    input  wire logic [31:0] reqBitMask,
    input  wire logic        reqMaskEnable,
    // Read return
    output logic             rdValid,
    input  wire logic        rdReady,
    output logic [31:0]      rdData,
    // DRAM pins
    output logic [3:0]       rowStrobe_n,
    output logic [3:0]       evenBankColumnStrobes_n,
    output logic [3:0]       oddBankColumnStrobes_n,
    output logic [8:0]       evenBankAddressBus,
    output logic [8:0]       oddBankAddressBus,
    output logic             writeEnable_n,
    output logic             outputEnable_n,
    input  wire logic [31:0] memoryDataBusIn,
    output logic [31:0]      memoryDataBusOut,
    output logic             memoryDataBusOe
);
    fbdc_pkg::fbdc_state_t state_reg;
    fbdc_pkg::fbdc_state_t preTarget_reg;
    logic [2:0]  waitCnt_reg;
    logic [1:0]  curBank_reg;
    logic [8:0]  curRow_reg;
    logic [8:0]  curCol_reg;
    logic [3:0]  curLanes_reg;
    logic [1:0]  curShift_reg;
    logic [1:0]  curSize_reg;
    logic        curWrite_reg;
    logic        curHyper_reg;
    logic        curMasked_reg;
    logic [31:0] curData_reg;
    logic [31:0] curMask_reg;
    logic [1:0]  openValid_reg;
    logic [1:0]  openHigh_reg;
    logic [8:0]  openRow_reg [2];
    logic [fbdc_pkg::REFRESH_CNT_W-1:0] refreshCnt_reg;
    logic        refreshPending_reg;
    logic        reqReady_reg;

    logic        interleaveOn;
    logic        hyperOn;
    logic [19:0] wordAddr;
    logic [1:0]  reqBank;
    logic [8:0]  reqRow;
    logic [8:0]  reqCol;
    logic        reqParity;
    logic        pageHit;
    logic        accept;
    logic        refreshTick;
    logic        refreshGrant;
    logic        fifoPush;
    logic        fifoInReady;

    // Byte lanes touched by an access of the given size
    function automatic logic [3:0] laneMask(input logic [1:0] size,
                                            input logic [1:0] shift);
        unique case (size)
            fbdc_pkg::SIZE_BYTE: laneMask = 4'(4'h1 << shift);
            fbdc_pkg::SIZE_HALF: laneMask = shift[1] ? 4'hC : 4'h3;
            default:             laneMask = 4'hF;
        endcase
    endfunction

    // Moves a read unit to the low end
    function automatic logic [31:0] alignRead(input logic [31:0] word,
                                              input logic [1:0]  size,
                                              input logic [1:0]  shift);
        logic [31:0] moved;
        moved = word >> {shift, 3'h0};
        unique case (size)
            fbdc_pkg::SIZE_BYTE: alignRead = {24'h000000, moved[7:0]};
            fbdc_pkg::SIZE_HALF: alignRead = {16'h0000, moved[15:0]};
            default:             alignRead = word;
        endcase
    endfunction

    assign accept       = reqValid && reqReady_reg;
    assign refreshTick  = refreshCnt_reg ==
                          fbdc_pkg::REFRESH_CNT_W'(fbdc_pkg::REFRESH_CYCLES - 1);
    assign refreshGrant = clkEn && state_reg == fbdc_pkg::ST_REFRESH &&
                          waitCnt_reg == 3'h0;
    assign reqReady     = reqReady_reg;

    // Interleave only for standard DRAM layouts
    always_comb begin
        interleaveOn = !cfgEdoDram &&
            ((cfgBankCount == fbdc_pkg::BANKS_TWO && !cfgWideDac) ||
             (cfgBankCount == fbdc_pkg::BANKS_FOUR && cfgWideDac));
        hyperOn = cfgEdoDram &&
            (cfgBankCount == fbdc_pkg::BANKS_ONE || cfgWideDac);
    end

    // Byte address to bank, row and column
    always_comb begin
        wordAddr = reqAddr[21:2];
        if (interleaveOn) begin
            reqCol  = wordAddr[9:1];
            reqRow  = wordAddr[18:10];
            reqBank = {wordAddr[19], wordAddr[0]};
        end else begin
            reqCol  = wordAddr[8:0];
            reqRow  = wordAddr[17:9];
            reqBank = wordAddr[19:18];
        end
        unique case (cfgBankCount)
            fbdc_pkg::BANKS_ONE: reqBank = 2'h0;
            fbdc_pkg::BANKS_TWO: reqBank[1] = 1'b0;
            default:             reqBank = reqBank;
        endcase
        reqParity = reqBank[0];
        pageHit   = openValid_reg[reqParity] &&
                    openHigh_reg[reqParity] == reqBank[1] &&
                    openRow_reg[reqParity] == reqRow;
    end

    // Refresh timer, free running
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            refreshCnt_reg     <= '0;
            refreshPending_reg <= 1'b0;
        end else if (clkEn) begin
            refreshCnt_reg <= refreshTick ? '0 : refreshCnt_reg + 1'b1;
            // A tick in the grant cycle is kept
            if (refreshTick) begin
                refreshPending_reg <= 1'b1;
            end else if (refreshGrant) begin
                refreshPending_reg <= 1'b0;
            end
        end
    end

    // Ready is offered one idle cycle ahead, so a read always has room
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reqReady_reg <= 1'b0;
        end else if (clkEn) begin
            reqReady_reg <= state_reg == fbdc_pkg::ST_IDLE && !accept &&
                            !refreshPending_reg && !refreshTick &&
                            fifoInReady;
        end
    end

    assign fifoPush = clkEn && !curWrite_reg &&
        ((state_reg == fbdc_pkg::ST_HOLD && !curHyper_reg) ||
         (state_reg == fbdc_pkg::ST_CASUP && curHyper_reg));

    // Cycle sequencer and DRAM pins
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_reg               <= fbdc_pkg::ST_IDLE;
            preTarget_reg           <= fbdc_pkg::ST_IDLE;
            waitCnt_reg             <= 3'h0;
            curBank_reg             <= 2'h0;
            curRow_reg              <= 9'h000;
            curCol_reg              <= 9'h000;
            curLanes_reg            <= 4'h0;
            curShift_reg            <= 2'h0;
            curSize_reg             <= 2'h0;
            curWrite_reg            <= 1'b0;
            curHyper_reg            <= 1'b0;
            curMasked_reg           <= 1'b0;
            curData_reg             <= 32'h00000000;
            curMask_reg             <= 32'h00000000;
            openValid_reg           <= 2'h0;
            openHigh_reg            <= 2'h0;
            openRow_reg[0]          <= 9'h000;
            openRow_reg[1]          <= 9'h000;
            rowStrobe_n             <= 4'hF;
            evenBankColumnStrobes_n <= 4'hF;
            oddBankColumnStrobes_n  <= 4'hF;
            evenBankAddressBus      <= 9'h000;
            oddBankAddressBus       <= 9'h000;
            writeEnable_n           <= 1'b1;
            outputEnable_n          <= 1'b1;
            memoryDataBusOut        <= 32'h00000000;
            memoryDataBusOe         <= 1'b0;
        end else if (clkEn) begin
            unique case (state_reg)
                fbdc_pkg::ST_IDLE: begin
                    if (accept) begin
                        curBank_reg   <= reqBank;
                        curRow_reg    <= reqRow;
                        curCol_reg    <= reqCol;
                        curShift_reg  <= reqAddr[1:0];
                        curSize_reg   <= reqSize;
                        curLanes_reg  <= laneMask(reqSize, reqAddr[1:0]);
                        curWrite_reg  <= reqWrite;
                        curHyper_reg  <= hyperOn && !reqWrite;
                        curMasked_reg <= reqWrite && reqMaskEnable;
                        curData_reg   <= reqWriteData << {reqAddr[1:0], 3'h0};
                        curMask_reg   <= reqBitMask;
                        waitCnt_reg   <= 3'h0;
                        if (openValid_reg[reqParity] &&
                            (!pageHit || (reqWrite && reqMaskEnable))) begin
                            // Masked writes always open a fresh row
                            rowStrobe_n[{openHigh_reg[reqParity],
                                         reqParity}] <= 1'b1;
                            openValid_reg[reqParity] <= 1'b0;
                            preTarget_reg <= fbdc_pkg::ST_ROW;
                            waitCnt_reg   <= fbdc_pkg::RAS_PRECHARGE_CYCLES -
                                             3'h1;
                            state_reg     <= fbdc_pkg::ST_PRECH;
                        end else if (pageHit) begin
                            state_reg <= fbdc_pkg::ST_COL;
                        end else begin
                            state_reg <= fbdc_pkg::ST_ROW;
                        end
                    end else if (refreshPending_reg) begin
                        waitCnt_reg <= 3'h0;
                        if (openValid_reg != 2'h0) begin
                            rowStrobe_n   <= 4'hF;
                            openValid_reg <= 2'h0;
                            preTarget_reg <= fbdc_pkg::ST_REFRESH;
                            waitCnt_reg   <= fbdc_pkg::RAS_PRECHARGE_CYCLES -
                                             3'h1;
                            state_reg     <= fbdc_pkg::ST_PRECH;
                        end else begin
                            state_reg <= fbdc_pkg::ST_REFRESH;
                        end
                    end
                end
                fbdc_pkg::ST_PRECH: begin
                    if (waitCnt_reg == 3'h0) begin
                        state_reg <= preTarget_reg;
                    end else begin
                        waitCnt_reg <= waitCnt_reg - 3'h1;
                    end
                end
                fbdc_pkg::ST_ROW: begin
                    waitCnt_reg <= waitCnt_reg + 3'h1;
                    if (waitCnt_reg == 3'h0) begin
                        if (curBank_reg[0]) begin
                            oddBankAddressBus <= curRow_reg;
                        end else begin
                            evenBankAddressBus <= curRow_reg;
                        end
                    end else if (waitCnt_reg == 3'h1) begin
                        rowStrobe_n[curBank_reg] <= 1'b0;
                        openValid_reg[curBank_reg[0]] <= 1'b1;
                        openHigh_reg[curBank_reg[0]]  <= curBank_reg[1];
                        openRow_reg[curBank_reg[0]]   <= curRow_reg;
                        if (curMasked_reg) begin
                            writeEnable_n    <= 1'b0;
                            memoryDataBusOut <= curMask_reg;
                            memoryDataBusOe  <= 1'b1;
                        end
                    end else if (waitCnt_reg == 3'h2) begin
                        writeEnable_n   <= 1'b1;
                        memoryDataBusOe <= 1'b0;
                    end
                    if (waitCnt_reg == fbdc_pkg::RAS_TO_CAS_CYCLES + 3'h1) begin
                        state_reg <= fbdc_pkg::ST_COL;
                    end
                end
                fbdc_pkg::ST_COL: begin
                    if (curBank_reg[0]) begin
                        oddBankAddressBus <= curCol_reg;
                    end else begin
                        evenBankAddressBus <= curCol_reg;
                    end
                    if (curWrite_reg) begin
                        memoryDataBusOut <= curData_reg;
                        memoryDataBusOe  <= 1'b1;
                    end else begin
                        outputEnable_n <= 1'b0;
                    end
                    state_reg <= fbdc_pkg::ST_STROBE;
                end
                fbdc_pkg::ST_STROBE: begin
                    if (curBank_reg[0]) begin
                        oddBankColumnStrobes_n <= ~curLanes_reg;
                    end else begin
                        evenBankColumnStrobes_n <= ~curLanes_reg;
                    end
                    if (curWrite_reg) begin
                        state_reg <= fbdc_pkg::ST_HOLD;
                    end else if (curHyper_reg) begin
                        state_reg <= fbdc_pkg::ST_CASUP;
                    end else begin
                        state_reg <= fbdc_pkg::ST_HOLD;
                    end
                end
                fbdc_pkg::ST_HOLD: begin
                    // Write strobe follows the column strobe
                    if (curWrite_reg) begin
                        writeEnable_n <= 1'b0;
                        state_reg     <= fbdc_pkg::ST_CASUP;
                    end else begin
                        evenBankColumnStrobes_n <= 4'hF;
                        oddBankColumnStrobes_n  <= 4'hF;
                        state_reg <= fbdc_pkg::ST_CASUP;
                    end
                end
                fbdc_pkg::ST_CASUP: begin
                    // EDO keeps the data after the strobe rises
                    evenBankColumnStrobes_n <= 4'hF;
                    oddBankColumnStrobes_n  <= 4'hF;
                    writeEnable_n   <= 1'b1;
                    outputEnable_n  <= 1'b1;
                    memoryDataBusOe <= 1'b0;
                    if (curMasked_reg) begin
                        rowStrobe_n[curBank_reg] <= 1'b1;
                        openValid_reg[curBank_reg[0]] <= 1'b0;
                        preTarget_reg <= fbdc_pkg::ST_IDLE;
                        waitCnt_reg   <= fbdc_pkg::RAS_PRECHARGE_CYCLES - 3'h1;
                        state_reg     <= fbdc_pkg::ST_PRECH;
                    end else begin
                        state_reg <= fbdc_pkg::ST_IDLE;
                    end
                end
                fbdc_pkg::ST_REFRESH: begin
                    waitCnt_reg <= waitCnt_reg + 3'h1;
                    if (waitCnt_reg == 3'h0) begin
                        evenBankColumnStrobes_n <= 4'h0;
                        oddBankColumnStrobes_n  <= 4'h0;
                    end else if (waitCnt_reg == 3'h1) begin
                        rowStrobe_n <= 4'h0;
                    end else if (waitCnt_reg ==
                                 fbdc_pkg::CBR_RAS_HOLD_CYCLES + 3'h1) begin
                        rowStrobe_n             <= 4'hF;
                        evenBankColumnStrobes_n <= 4'hF;
                        oddBankColumnStrobes_n  <= 4'hF;
                        preTarget_reg <= fbdc_pkg::ST_IDLE;
                        waitCnt_reg   <= fbdc_pkg::RAS_PRECHARGE_CYCLES - 3'h1;
                        state_reg     <= fbdc_pkg::ST_PRECH;
                    end
                end
            endcase
        end
    end

    // Read return buffer
    fbdc_fifo #(
        .WIDTH (fbdc_pkg::DATA_W),
        .DEPTH (fbdc_pkg::RETURN_DEPTH)
    ) returnFifo (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .clkEn    (clkEn),
        .inValid  (fifoPush),
        .inReady  (fifoInReady),
        .inData   (alignRead(memoryDataBusIn, curSize_reg, curShift_reg)),
        .outValid (rdValid),
        .outReady (rdReady),
        .outData  (rdData)
    );
endmodule

// ==== fbdc_dram_ctrl_assertions.sv ====
// Port checks for the DRAM controller
`timescale 1ns/1ps
module fbdc_dram_ctrl_assertions (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        reset_n,
    // Requests and return
    input wire logic        reqValid,
    input wire logic        reqReady,
    input wire logic        rdValid,
    input wire logic        rdReady,
    input wire logic [31:0] rdData,
    // DRAM pins
    input wire logic [3:0]  rowStrobe_n,
    input wire logic [3:0]  evenBankColumnStrobes_n,
    input wire logic        writeEnable_n,
    input wire logic        outputEnable_n,
    input wire logic        memoryDataBusOe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic [10:0] sinceCbr;
    // Held at zero while all row strobes are low
    always_ff @(posedge ref_clk) begin
        if (!reset_n || rowStrobe_n == 4'h0) begin
            sinceCbr <= 11'h000;
        end else begin
            sinceCbr <= sinceCbr + 11'h001;
        end
    end
    sequence cbrStart;
        rowStrobe_n == 4'h0 && $past(rowStrobe_n) == 4'hF;
    endsequence
    chk_take_drops_ready:
    assert property (reqValid && reqReady |=> !reqReady)
        else $error("ready held after take");
    chk_cas_before_ras:
    assert property (cbrStart |-> $past(evenBankColumnStrobes_n) == 4'h0)
        else $error("row strobes fell first");
    chk_cbr_ras_width:
    assert property (cbrStart |-> rowStrobe_n == 4'h0 [*4]
                     ##1 rowStrobe_n == 4'hF)
        else $error("refresh width wrong");
    chk_refresh_spacing:
    assert property (cbrStart |-> sinceCbr >= 11'd700 && sinceCbr <= 11'd816)
        else $error("refresh spacing off");
    chk_refresh_due:
    assert property (sinceCbr <= 11'd816)
        else $error("refresh overdue");
    chk_no_bus_fight:
    assert property (memoryDataBusOe |-> outputEnable_n)
        else $error("data bus fight");
    chk_write_drives_bus:
    assert property (!writeEnable_n |-> memoryDataBusOe)
        else $error("write without data");
    chk_return_hold:
    assert property (rdValid && !rdReady |=> rdValid && $stable(rdData))
        else $error("return data moved");
    chk_reset_idle:
    assert property ($rose(reset_n) |-> rowStrobe_n == 4'hF && !reqReady)
        else $error("not idle after reset");
    cover property (cbrStart);
    cover property (!writeEnable_n);
    cover property (reqValid && !reqReady && rdValid && !rdReady);
endmodule
bind fbdc_dram_ctrl fbdc_dram_ctrl_assertions u_chk (.ref_clk, .reset_n,
    .reqValid, .reqReady, .rdValid, .rdReady, .rdData, .rowStrobe_n,
    .evenBankColumnStrobes_n, .writeEnable_n, .outputEnable_n,
    .memoryDataBusOe);

// ==== fbdc_dram_model.sv ====
// Behavioural pair of 256Kx16 DRAMs forming bank 0, row ignored
`timescale 1ns/1ps
module fbdc_dram_model (
    // Strobes and address
    input wire logic        ref_clk,
    input wire logic [3:0]  rowStrobe_n,
    input wire logic [3:0]  evenBankColumnStrobes_n,
    input wire logic [8:0]  evenBankAddressBus,
    input wire logic        writeEnable_n,
    input wire logic        outputEnable_n,
    // Data
    input wire logic [31:0] memoryDataBusOut,
    output logic [31:0]     memoryDataBusIn
);
    logic [31:0] mem [512];
    logic [31:0] lastIn, maskReg, lanes, wbits;
    logic        rasPrev;
    wire  [3:0]  cs = ~evenBankColumnStrobes_n;
    assign lanes = {{8{cs[3]}}, {8{cs[2]}}, {8{cs[1]}}, {8{cs[0]}}};
    assign wbits = lanes & maskReg;
    // Released bus inverts so stale data never passes
    assign memoryDataBusIn = !outputEnable_n ? mem[evenBankAddressBus]
                                             : ~lastIn;
    always_ff @(posedge ref_clk) begin
        lastIn <= memoryDataBusIn;
        rasPrev <= rowStrobe_n[0];
        if (rowStrobe_n[0]) begin
            maskReg <= 32'hFFFFFFFF;
        end else if (rasPrev && !writeEnable_n) begin
            maskReg <= memoryDataBusOut;
        end
        if (!writeEnable_n && cs != 4'h0) begin
            mem[evenBankAddressBus] <= mem[evenBankAddressBus] & ~wbits
                                       | memoryDataBusOut & wbits;
        end
    end
endmodule

// ==== tb.sv ====
// Self-checking bench for the DRAM controller
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0, reset_n = 1'b0, reqValid = 1'b0, rdReady = 1'b0;
    logic reqWrite = 1'b0, reqMaskEnable = 1'b0, reqReady, rdValid;
    logic [21:0] reqAddr = 22'h000000;
    logic [1:0]  reqSize = 2'h0;
    logic [31:0] reqWriteData = 32'h0, reqBitMask = 32'h0000FF00, rdData;
    logic [31:0] memoryDataBusIn, memoryDataBusOut;
    logic [8:0]  evenBankAddressBus;
    logic [3:0]  rowStrobe_n, evenBankColumnStrobes_n;
    logic        writeEnable_n, outputEnable_n;
    int          n_fail = 0, compares = 0, i;
    always #5 ref_clk = ~ref_clk;
    fbdc_dram_ctrl dut (.ref_clk, .reset_n, .clkEn(1'b1),
        .cfgBankCount(fbdc_pkg::BANKS_ONE), .cfgWideDac(1'b0),
        .cfgEdoDram(1'b0), .reqValid, .reqReady, .reqWrite, .reqAddr,
        .reqSize, .reqWriteData, .reqBitMask, .reqMaskEnable, .rdValid,
        .rdReady, .rdData, .rowStrobe_n, .evenBankColumnStrobes_n,
        .oddBankColumnStrobes_n(), .evenBankAddressBus,
        .oddBankAddressBus(), .writeEnable_n, .outputEnable_n,
        .memoryDataBusIn, .memoryDataBusOut, .memoryDataBusOe());
    fbdc_dram_model mdl (.ref_clk, .rowStrobe_n, .evenBankColumnStrobes_n,
        .evenBankAddressBus, .writeEnable_n, .outputEnable_n,
        .memoryDataBusOut, .memoryDataBusIn);
    task automatic chk(input logic [31:0] seen, exp, input string nm);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic req(input logic w, m, input logic [21:0] a,
                       input logic [1:0] s, input logic [31:0] d);
        reqWrite <= w;
        reqMaskEnable <= m;
        reqAddr <= a;
        reqSize <= s;
        reqWriteData <= d;
        reqValid <= 1'b1;
        do @(posedge ref_clk); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic pop(input logic [31:0] exp);
        while (rdValid !== 1'b1) @(posedge ref_clk);
        chk(rdData, exp, "rdData");
        rdReady <= 1'b1;
        @(posedge ref_clk);
        rdReady <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [21:0] a, input logic [1:0] s,
                      input logic [31:0] exp);
        req(1'b0, 1'b0, a, s, 32'h0);
        pop(exp);
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        end_sim;
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        req(1'b1, 1'b0, 22'h10, fbdc_pkg::SIZE_WORD, 32'h12345678);
        rd(22'h10, fbdc_pkg::SIZE_WORD, 32'h12345678);
        req(1'b1, 1'b0, 22'h11, fbdc_pkg::SIZE_BYTE, 32'h000000A5);
        rd(22'h10, fbdc_pkg::SIZE_WORD, 32'h1234A578);
        rd(22'h11, fbdc_pkg::SIZE_BYTE, 32'h000000A5);
        rd(22'h12, fbdc_pkg::SIZE_HALF, 32'h00001234);
        req(1'b1, 1'b1, 22'h10, fbdc_pkg::SIZE_WORD, 32'hFFFFFFFF);
        rd(22'h10, fbdc_pkg::SIZE_WORD, 32'h1234FF78);
        req(1'b1, 1'b0, 22'h14, fbdc_pkg::SIZE_WORD, 32'hCAFE0001);
        req(1'b1, 1'b0, 22'h10, fbdc_pkg::SIZE_WORD, 32'h0);
        // Stalled drain fills the return buffer
        for (i = 0; i < 4; i++)
            req(1'b0, 1'b0, 22'h10 | 22'(i % 2 * 4), fbdc_pkg::SIZE_WORD, 32'h0);
        repeat (30) @(posedge ref_clk);
        chk({31'h0, reqReady}, 32'h0, "reqReady");
        for (i = 0; i < 4; i++)
            pop(i % 2 == 1 ? 32'hCAFE0001 : 32'h0);
        chk({31'h0, rdValid}, 32'h0, "rdValid");
        repeat (1700) @(posedge ref_clk);
        rd(22'h14, fbdc_pkg::SIZE_WORD, 32'hCAFE0001);
        end_sim;
    end
endmodule
